/* core/gpm_pin_mode_config.sv */
// Pin mode configuration, output path and boot pin capture for three ports
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module gpm_pin_mode_config
   import gpm_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic [31:0]          hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   input  wire logic [NPIN-1:0] pinIn,
   output logic [NPIN-1:0]      padOut,
   output logic [NPIN-1:0]      padOeN,
   output logic [NPIN-1:0]      pullUpEn,
   output logic [NPIN-1:0]      pullDownEn,
   output logic [NPIN-1:0]      analogEn,
   output logic [NPIN-1:0]      periphIn,
   input  wire logic [NPIN-1:0] periphAltOut,
   input  wire logic [NPIN-1:0] periphAltHas,
   input  wire logic [3:0]      timerBRouteOption,
   input  wire logic [3:0]      timerBChanEn,
   input  wire logic [3:0]      timerBChanOut,
   input  wire logic            packetTraceFrame,
   input  wire logic            packetTraceSerial,
   input  wire logic            cpuTraceBit2,
   input  wire logic            cpuTraceBit3,
   input  wire logic            regEnable,
   input  wire logic            debugFourWire,
   input  wire logic            debugTwoWire,
   input  wire logic            debugFourWireOut,
   input  wire logic            debugTwoWireOut,
   input  wire logic            debugTwoWireDrive,
   input  wire logic            bootResetKind,
   output logic                 bootLoaderSelect,
   output logic                 bootDone
);

   // ----------------------------------------------------------------
   // Pad decode
   // ----------------------------------------------------------------
   // Result bits: [4] out, [3] enable (low drives), [2] up, [1] down, [0] analog
   function automatic logic [4:0] gpm_pad(input logic [3:0] md, input logic lat,
                                          input logic alt);
      logic [4:0] r;
      r = 5'h08;                                  // Floating input, driver off
      case (md)
         MODE_ANALOG:   r = 5'h09;
         MODE_IN_PULL:  r = {2'b01, lat, ~lat, 1'b0};
         MODE_OUT_PP:   r = {lat, 4'h0};
         MODE_OUT_OD:   r = {1'b0, lat, 3'h0};
         MODE_ALT_PP,
         MODE_ALT_SCLK: r = {alt, 4'h0};
         MODE_ALT_OD:   r = {1'b0, alt, 3'h0};
         default:       r = 5'h08;                // Unused codes stay passive
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // State and next state
   // ----------------------------------------------------------------
   gpm_state_t           s;                       // Registered state
   gpm_state_t           n;                       // Next state
   logic [NPIN-1:0]      alt;                     // Alternate output values
   logic [NPIN-1:0][3:0] effMode;                 // Mode after forced functions
   logic [NPIN-1:0]      effLat;                  // Latch after forced functions
   logic [4:0]           pad;
   logic [4:0]           base;                    // First pin of addressed port
   logic                 portHit;
   logic                 accept;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      n = s;
      // Alternate sources; pins with no peripheral see zero
      alt = periphAltOut & periphAltHas;
      for (int k = 0; k < 4; k++) begin
         if (timerBChanEn[k]) begin
            alt[timerBRouteOption[k] ? TIMB_PIN_B[k] : TIMB_PIN_A[k]] = timerBChanOut[k];
         end
      end
      alt[PIN_TRACE_FRAME] = s.traceSel ? cpuTraceBit2 : packetTraceFrame;
      alt[PIN_BOOT] = s.traceSel ? cpuTraceBit3 : packetTraceSerial;
      // Forced functions override the stored modes
      effMode = s.mode;
      effLat = s.latch;
      if (s.extReg) begin
         effMode[PIN_REGEN] = MODE_ALT_OD;
         alt[PIN_REGEN] = regEnable;
      end
      if (!s.dbgDis && debugFourWire) begin
         effMode[PIN_DBG_RST] = MODE_IN_PULL;
         effMode[PIN_DBG_IN] = MODE_IN_PULL;
         effMode[PIN_DBG_SEL] = MODE_IN_PULL;
         effLat[PIN_DBG_RST] = 1'b1;
         effLat[PIN_DBG_IN] = 1'b1;
         effLat[PIN_DBG_SEL] = 1'b1;
         effMode[PIN_DBG_OUT] = MODE_ALT_PP;
         alt[PIN_DBG_OUT] = debugFourWireOut;
      end else if (!s.dbgDis && debugTwoWire) begin
         effMode[PIN_DBG_SEL] = debugTwoWireDrive ? MODE_ALT_PP : MODE_IN_FLOAT;
         alt[PIN_DBG_SEL] = debugTwoWireOut;
      end
      if (s.boot == BOOT_HOLD) begin
         effMode[PIN_BOOT] = MODE_IN_PULL;
         effLat[PIN_BOOT] = 1'b1;
      end
      // Two-flop synchroniser on the pad levels
      n.syncA = pinIn;
      n.syncB = s.syncA;
      // Pad controls, one pin at a time
      pad = 5'h08;
      for (int i = 0; i < NPIN; i++) begin
         pad = gpm_pad(effMode[i], effLat[i], alt[i]);
         n.pOut[i] = pad[4];
         n.pOeN[i] = pad[3];
         n.pUp[i] = pad[2];
         n.pDn[i] = pad[1];
         n.pAna[i] = pad[0];
         // Analog ties the input high; all else sees the pin
         n.pIn[i] = (effMode[i] == MODE_ANALOG) ? 1'b1 : s.syncB[i];
      end
      // Boot pin hold and capture
      case (s.boot)
         BOOT_HOLD: begin
            n.bootCnt = s.bootCnt + 1'b1;
            if (s.bootCnt == BOOT_LAST) begin
               n.boot = BOOT_DONE;
               n.bootSel = ~s.syncB[PIN_BOOT];
            end
         end
         default: begin
            n.bootCnt = s.bootCnt;                // Level stays until reset
         end
      endcase
      // Write in data phase
      base = {s.dAddr[6:5], 3'b000};
      portHit = !s.dAddr[7] && (s.dAddr[6:5] != 2'b11);
      if (s.dAct && s.dWr) begin
         if (s.dAddr == OFS_DBG_CFG) begin
            n.extReg = hwdata[DBGCFG_EXTREG];
            n.dbgDis = hwdata[DBGCFG_DEBUGDIS];
            n.traceSel = hwdata[DBGCFG_TRACESEL];
         end else if (portHit && s.dAddr[4:0] == OFS_CFG_LOW) begin
            n.mode[base +: 4] = hwdata[15:0];
         end else if (portHit && s.dAddr[4:0] == OFS_CFG_HIGH) begin
            n.mode[base + 5'd4 +: 4] = hwdata[15:0];
         end else if (portHit && s.dAddr[4:0] == OFS_OUT) begin
            n.latch[base +: 8] = hwdata[7:0];
         end else if (portHit && s.dAddr[4:0] == OFS_SET) begin
            n.latch[base +: 8] = s.latch[base +: 8] | hwdata[7:0];
         end else if (portHit && s.dAddr[4:0] == OFS_CLR) begin
            n.latch[base +: 8] = s.latch[base +: 8] & ~hwdata[7:0];
         end
      end
      // Address phase; read data is formed from the next state so that a write
      // just ahead of a read of the same register is already visible
      accept = hsel && hready && htrans[1];
      n.dAct = accept;
      n.dWr = hwrite;
      n.dAddr = haddr[7:0];
      n.rdata = 32'h0;
      base = {haddr[6:5], 3'b000};
      portHit = !haddr[7] && (haddr[6:5] != 2'b11);
      if (!accept || hwrite) begin
         n.rdata = 32'h0;                         // Nothing to return
      end else if (haddr[7:0] == OFS_DBG_CFG) begin
         n.rdata[DBGCFG_EXTREG] = n.extReg;
         n.rdata[DBGCFG_DEBUGDIS] = n.dbgDis;
         n.rdata[DBGCFG_TRACESEL] = n.traceSel;
      end else if (haddr[7:0] == OFS_DBG_STAT) begin
         n.rdata[DBGSTAT_BOOT] = n.bootSel;
         n.rdata[DBGSTAT_FOUR] = !n.dbgDis && debugFourWire;
         n.rdata[DBGSTAT_TWO] = !n.dbgDis && !debugFourWire && debugTwoWire;
      end else if (portHit && haddr[4:0] == OFS_CFG_LOW) begin
         n.rdata[15:0] = n.mode[base +: 4];
      end else if (portHit && haddr[4:0] == OFS_CFG_HIGH) begin
         n.rdata[15:0] = n.mode[base + 5'd4 +: 4];
      end else if (portHit && haddr[4:0] == OFS_IN) begin
         n.rdata[7:0] = n.pIn[base +: 8];
      end else if (portHit && haddr[4:0] == OFS_OUT) begin
         n.rdata[7:0] = n.latch[base +: 8];
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Full reset: floating inputs, regulator override on, debug allowed
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s <= '0;
         s.mode <= {NPIN{RST_MODE}};
         s.extReg <= RST_EXTREG;
         s.dbgDis <= RST_DEBUGDIS;
         s.traceSel <= RST_TRACESEL;
         s.pOeN <= '1;
         s.pIn <= '1;
         // Only pin and power-on resets run the boot pin hold
         s.boot <= bootResetKind ? BOOT_HOLD : BOOT_DONE;
         s.pUp[PIN_BOOT] <= bootResetKind;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hrdata = s.rdata;
   assign hreadyout = 1'b1;                       // Zero wait states
   assign hresp = 1'b0;                           // Always OKAY
   assign padOut = s.pOut;
   assign padOeN = s.pOeN;
   assign pullUpEn = s.pUp;
   assign pullDownEn = s.pDn;
   assign analogEn = s.pAna;
   assign periphIn = s.pIn;
   assign bootLoaderSelect = s.bootSel;
   assign bootDone = (s.boot == BOOT_DONE);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   localparam int AP = 8;                         // A pin with no forced function
   localparam int NP = 13;                        // No timer channel is ever routed here

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence s_setWrite;
      s.dAct && s.dWr && s.dAddr == {3'b000, OFS_SET};
   endsequence
   sequence s_clrWrite;
      s.dAct && s.dWr && s.dAddr == {3'b000, OFS_CLR};
   endsequence
   sequence s_bootEnd;
      s.boot == BOOT_HOLD && s.bootCnt == BOOT_LAST;
   endsequence

   property p_analog;
      s.mode[AP] == MODE_ANALOG |=> periphIn[AP] && padOeN[AP] && !pullUpEn[AP] && !pullDownEn[AP];
   endproperty
   a_analog: assert property (p_analog) else $error("analog pin not passive");
   property p_pull;
      s.mode[AP] == MODE_IN_PULL |=> pullUpEn[AP] == $past(s.latch[AP]) && pullDownEn[AP] != pullUpEn[AP];
   endproperty
   a_pull: assert property (p_pull) else $error("pull choice wrong");
   property p_pushpull;
      s.mode[AP] == MODE_OUT_PP |=> !padOeN[AP] && padOut[AP] == $past(s.latch[AP]) && !pullUpEn[AP];
   endproperty
   a_pushpull: assert property (p_pushpull) else $error("push-pull drive wrong");
   property p_opendrain;
      s.mode[AP] == MODE_OUT_OD |=> padOeN[AP] == $past(s.latch[AP]) && !padOut[AP];
   endproperty
   a_opendrain: assert property (p_opendrain) else $error("open-drain drive wrong");
   property p_altnone;
      s.mode[NP] == MODE_ALT_PP && !periphAltHas[NP] |=> !padOut[NP] && !padOeN[NP];
   endproperty
   a_altnone: assert property (p_altnone) else $error("unowned alternate pin not zero");
   property p_timer;
      s.mode[0] == MODE_ALT_PP && timerBChanEn[0] && !timerBRouteOption[0] |=> padOut[0] == $past(timerBChanOut[0]);
   endproperty
   a_timer: assert property (p_timer) else $error("timer channel not on pin");
   property p_set;
      s_setWrite |=> s.latch[7:0] == ($past(s.latch[7:0]) | $past(hwdata[7:0]));
   endproperty
   a_set: assert property (p_set) else $error("set register wrong");
   property p_clr;
      s_clrWrite |=> s.latch[7:0] == ($past(s.latch[7:0]) & ~$past(hwdata[7:0]));
   endproperty
   a_clr: assert property (p_clr) else $error("clear register wrong");
   property p_readback;
      s.dAct && !s.dWr && s.dAddr == {3'b000, OFS_OUT} |-> hrdata[7:0] == s.latch[7:0];
   endproperty
   a_readback: assert property (p_readback) else $error("latch readback wrong");
   property p_regen;
      s.extReg |=> padOeN[PIN_REGEN] == $past(regEnable) && !padOut[PIN_REGEN];
   endproperty
   a_regen: assert property (p_regen) else $error("regulator pin not forced");
   property p_bootend;
      s_bootEnd |=> bootDone && bootLoaderSelect == !$past(s.syncB[PIN_BOOT]);
   endproperty
   a_bootend: assert property (p_bootend) else $error("boot pin capture wrong");
   property p_boothold;
      !bootDone |-> pullUpEn[PIN_BOOT] && padOeN[PIN_BOOT] ##1 (bootDone || pullUpEn[PIN_BOOT]);
   endproperty
   a_boothold: assert property (p_boothold) else $error("boot pin not pulled up");

endmodule
`default_nettype wire

/* core/gpm_pkg.sv */
// Constants, codes, offsets and types for the pin mode configuration block
package gpm_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NPIN = 24;                     // Three ports of eight pins
   localparam int BOOT_CNT_W = 10;               // Width of the boot hold counter

   // ----------------------------------------------------------------
   // Pin mode codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_ANALOG   = 4'h0;
   localparam logic [3:0] MODE_IN_FLOAT = 4'h4;
   localparam logic [3:0] MODE_IN_PULL  = 4'h8;
   localparam logic [3:0] MODE_OUT_PP   = 4'h1;
   localparam logic [3:0] MODE_OUT_OD   = 4'h5;
   localparam logic [3:0] MODE_ALT_PP   = 4'h9;
   localparam logic [3:0] MODE_ALT_SCLK = 4'hb;
   localparam logic [3:0] MODE_ALT_OD   = 4'hd;

   // ----------------------------------------------------------------
   // Register offsets (per-port offsets are within one port slot)
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_CFG_LOW  = 5'h00;  // pin_mode_low_half
   localparam logic [4:0] OFS_CFG_HIGH = 5'h04;  // pin_mode_high_half
   localparam logic [4:0] OFS_IN       = 5'h08;  // pin_input_level
   localparam logic [4:0] OFS_OUT      = 5'h0c;  // output_latch
   localparam logic [4:0] OFS_SET      = 5'h10;  // output_latch_setter
   localparam logic [4:0] OFS_CLR      = 5'h14;  // output_latch_clearer
   localparam logic [7:0] OFS_DBG_CFG  = 8'h60;  // debug_misc_config
   localparam logic [7:0] OFS_DBG_STAT = 8'h64;  // debug_misc_status

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int DBGCFG_EXTREG   = 0;           // ext_regulator_ctrl_en
   localparam int DBGCFG_DEBUGDIS = 1;           // debugger_disable
   localparam int DBGCFG_TRACESEL = 2;           // 1: cpu trace on port A bits 4, 5
   localparam int DBGSTAT_BOOT    = 0;           // boot_pin_capture
   localparam int DBGSTAT_FOUR    = 1;           // Four-wire debug in force
   localparam int DBGSTAT_TWO     = 2;           // Two-wire debug in force

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [3:0] RST_MODE     = MODE_IN_FLOAT;
   localparam logic       RST_EXTREG   = 1'b1;
   localparam logic       RST_DEBUGDIS = 1'b0;
   localparam logic       RST_TRACESEL = 1'b0;

   // ----------------------------------------------------------------
   // Fixed pin positions
   // ----------------------------------------------------------------
   localparam logic [4:0] PIN_TRACE_FRAME = 5'd4;
   localparam logic [4:0] PIN_BOOT        = 5'd5;
   localparam logic [4:0] PIN_REGEN       = 5'd7;
   localparam logic [4:0] PIN_DBG_RST     = 5'd16;
   localparam logic [4:0] PIN_DBG_OUT     = 5'd18;
   localparam logic [4:0] PIN_DBG_IN      = 5'd19;
   localparam logic [4:0] PIN_DBG_SEL     = 5'd20;
   // Timer channel k goes to TIMB_PIN_A[k] or TIMB_PIN_B[k]
   localparam logic [3:0][4:0] TIMB_PIN_A = {5'd2, 5'd1, 5'd3, 5'd0};
   localparam logic [3:0][4:0] TIMB_PIN_B = {5'd12, 5'd11, 5'd10, 5'd9};

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 100;
   localparam int FAST_OSC_PERIOD_NS = 100;      // Fast oscillator period
   localparam int BOOT_HOLD_PERIODS = 512;
   localparam int BOOT_HOLD_CYC =
      (BOOT_HOLD_PERIODS * FAST_OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [BOOT_CNT_W-1:0] BOOT_LAST = BOOT_CNT_W'(BOOT_HOLD_CYC - 1);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {BOOT_HOLD = 1'b0, BOOT_DONE = 1'b1} gpm_boot_t;

   typedef struct packed {
      logic [NPIN-1:0][3:0]  mode;               // Per-pin mode codes
      logic [NPIN-1:0]       latch;              // Output latches
      logic                  extReg;
      logic                  dbgDis;
      logic                  traceSel;
      gpm_boot_t             boot;
      logic [BOOT_CNT_W-1:0] bootCnt;
      logic                  bootSel;            // 1: boot loader chosen
      logic [NPIN-1:0]       syncA;
      logic [NPIN-1:0]       syncB;
      logic [NPIN-1:0]       pOut;
      logic [NPIN-1:0]       pOeN;
      logic [NPIN-1:0]       pUp;
      logic [NPIN-1:0]       pDn;
      logic [NPIN-1:0]       pAna;
      logic [NPIN-1:0]       pIn;                // Level seen by software
      logic                  dAct;
      logic                  dWr;
      logic [7:0]            dAddr;
      logic [31:0]           rdata;
   } gpm_state_t;

endpackage

/* dv/gpm_far_side_model.sv */
// Far side model: peripheral alternate outputs and external pad levels
`timescale 1ns/1ns
`default_nettype none
module gpm_far_side_model
   import gpm_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic [NPIN-1:0] padOut,
   input  wire logic [NPIN-1:0] padOeN,
   input  wire logic [NPIN-1:0] pullUpEn,
   input  wire logic [NPIN-1:0] pullDownEn,
   input  wire logic [NPIN-1:0] extEn,
   input  wire logic [NPIN-1:0] extDrive,
   input  wire logic [NPIN-1:0] altPattern,
   input  wire logic [NPIN-1:0] altOwned,
   output logic      [NPIN-1:0] pinIn,
   output logic      [NPIN-1:0] periphAltOut,
   output logic      [NPIN-1:0] periphAltHas
);
   logic flt = 1'b0;                        // Level of a pad nobody holds
   // ----------------------------------------------------------------
   // Peripherals update just after the edge
   // ----------------------------------------------------------------
   // Unowned outputs toggle so that a leak into the pad shows up
   always_ff @(posedge clk_sys) begin
      flt          <= ~flt;
      periphAltHas <= altOwned;
      periphAltOut <= (altPattern & altOwned) | (~altOwned & {NPIN{flt}});
   end
   // Pad level: own driver, then external driver, then pulls, else drifting
   assign pinIn = (~padOeN & padOut) | (padOeN & extEn & extDrive)
                | (padOeN & ~extEn & (pullUpEn | (~pullDownEn & {NPIN{flt}})));
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the pin mode configuration block
`timescale 1ns/1ns
`default_nettype none
module testbench
   import gpm_pkg::*;
;
   logic            clk_sys = 0, rst = 1, hsel = 1, hwrite = 0, regEnable = 0, bootResetKind = 1;
   logic            debugFourWire = 0, debugTwoWire = 0, debugFourWireOut = 0;
   logic            packetTraceFrame = 0, packetTraceSerial = 0, cpuTraceBit2 = 0, cpuTraceBit3 = 0;
   logic            debugTwoWireOut = 0, debugTwoWireDrive = 0, hreadyout, hresp, bootLoaderSelect, bootDone;
   logic [31:0]     haddr = 0, hwdata = 0, hrdata;
   logic [1:0]      htrans = 0;
   logic [3:0]      timerBRouteOption = 0, timerBChanEn = 0, timerBChanOut = 0, m;
   logic [39:0]     ex;                     // Expected {oeN, up, down, analog, level}
   logic [NPIN-1:0] pinIn, padOut, padOeN, pullUpEn, pullDownEn, analogEn, periphIn, periphAltOut, periphAltHas;
   logic [NPIN-1:0] extEn = 24'h0000ff, extDrive = 24'h003cff;
   logic [3:0]      modeList [8] = '{MODE_ANALOG, MODE_IN_FLOAT, MODE_IN_PULL, MODE_OUT_PP,
                                     MODE_OUT_OD, MODE_ALT_PP, MODE_ALT_SCLK, MODE_ALT_OD};
   int              fails = 0, numChecks = 0;

   gpm_pin_mode_config DUT (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pinIn, .padOut, .padOeN, .pullUpEn, .pullDownEn,
      .analogEn, .periphIn, .periphAltOut, .periphAltHas, .timerBRouteOption, .timerBChanEn, .timerBChanOut,
      .packetTraceFrame, .packetTraceSerial, .cpuTraceBit2, .cpuTraceBit3,
      .regEnable, .debugFourWire, .debugTwoWire, .debugFourWireOut, .debugTwoWireOut, .debugTwoWireDrive,
      .bootResetKind, .bootLoaderSelect, .bootDone);
   gpm_far_side_model far (.clk_sys, .padOut, .padOeN, .pullUpEn, .pullDownEn, .extEn, .extDrive,
      .altPattern(24'h005a00), .altOwned(24'h000f00), .pinIn, .periphAltOut, .periphAltHas);

   // ----------------------------------------------------------------
   // Clock, watchdog and closing
   // ----------------------------------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // Both boot holds plus bus traffic stay far below this span
   initial begin
      #(100 * 6000);
      fails++;
      conclude();
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] e);
      numChecks++;
      if (got !== e) begin
         fails++;
         $display("BAD at %0t got %h expected %h", $time, got, e);
      end
   endtask
   // ----------------------------------------------------------------
   // Single AHB-Lite word transfer, holding each phase until hready
   // ----------------------------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      haddr  <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
      r = hrdata;
      cmp(32'(hresp), 32'h0);
      if (n >= 50) fails++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      cmp(r, e);
   endtask
   // Boot hold ends after a bounded wait
   task automatic waitBoot();
      repeat (700) if (bootDone !== 1'b1) @(posedge clk_sys);
   endtask
   // Synchronous reset for six cycles
   task automatic doReset();
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      doReset();
      cmp(32'({padOeN[7], pullUpEn[5]}), 32'h1);
      rdc(8'h00, 32'h4444);
      rdc(8'h44, 32'h4444);
      rdc(8'h60, 32'h1);
      regEnable <= 1'b1;
      debugFourWire <= 1'b1;
      debugFourWireOut <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cmp(32'({padOeN[7], pullUpEn[20:19], pullUpEn[16], padOeN[18], padOut[18]}), 32'h3d);
      rdc(8'h64, 32'h2);
      debugFourWire <= 1'b0;
      debugTwoWire <= 1'b1;
      debugTwoWireDrive <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cmp(32'({padOeN[20], padOut[20]}), 32'h0);
      wr(8'h60, 32'h2);
      repeat (3) @(posedge clk_sys);
      cmp(32'({padOeN[20], padOeN[7]}), 32'h3);
      waitBoot();
      repeat (2) @(posedge clk_sys);
      cmp(32'({bootDone, bootLoaderSelect, pullUpEn[5]}), 32'h4);
      // Same latch sequence on port A, then port B
      for (int p = 0; p < 64; p += 32) begin
         wr(8'(p + 12), 32'ha5);
         wr(8'(p + 16), 32'h0a);
         wr(8'(p + 20), 32'h81);
         rdc(8'(p + 12), 32'h2e);
      end
      rdc(8'h30, 32'h0);
      rdc(8'h7c, 32'h0);
      for (int i = 0; i < 8; i++) begin
         m = modeList[i];
         extEn[15:8] <= (m == MODE_IN_PULL) ? 8'h00 : 8'hff;
         wr(8'h20, {16'h0, {4{m}}});
         wr(8'h24, {16'h0, {4{m}}});
         repeat (6) @(posedge clk_sys);
         case (m)
            MODE_ANALOG:   ex = 40'hff_00_00_ff_ff;
            MODE_IN_FLOAT: ex = 40'hff_00_00_00_3c;
            MODE_IN_PULL:  ex = 40'hff_2e_d1_00_2e;
            MODE_OUT_PP:   ex = 40'h00_00_00_00_2e;
            MODE_OUT_OD:   ex = 40'h2e_00_00_00_2c;
            MODE_ALT_OD:   ex = 40'h0a_00_00_00_08;
            default:       ex = 40'h00_00_00_00_0a;
         endcase
         cmp({padOeN[15:8], pullUpEn[15:8], pullDownEn[15:8], analogEn[15:8]}, ex[39:8]);
         rdc(8'h28, {24'h0, ex[7:0]});
         cmp(32'(periphIn[15:8]), {24'h0, ex[7:0]});
      end
      rdc(8'h2c, 32'h2e);
      timerBChanEn <= 4'hf;
      timerBRouteOption <= 4'hf;
      timerBChanOut <= 4'b1010;
      repeat (4) @(posedge clk_sys);
      cmp(32'(padOeN[15:8]), 32'h14);
      timerBRouteOption <= 4'h0;
      repeat (4) @(posedge clk_sys);
      cmp(32'(padOeN[15:8]), 32'h0a);
      // Port A pins 0 to 5 as alternate push-pull: timers and packet trace
      wr(8'h00, 32'h9999);
      wr(8'h04, 32'h0099);
      packetTraceFrame <= 1'b1;
      cpuTraceBit3 <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cmp(32'(padOut[5:0]), 32'h1c);
      wr(8'h60, 32'h6);
      repeat (3) @(posedge clk_sys);
      cmp(32'(padOut[5:4]), 32'h2);
      debugTwoWire <= 1'b0;
      extEn[5] <= 1'b1;
      extDrive[5] <= 1'b0;
      doReset();
      rdc(8'h20, 32'h4444);
      rdc(8'h60, 32'h1);
      waitBoot();
      cmp(32'(bootLoaderSelect), 32'h1);
      rdc(8'h64, 32'h1);
      conclude();
   end
endmodule
`default_nettype wire
